// ==== lathe_panel_regs.svh ====
`ifndef LATHE_PANEL_REGS_SVH
`define LATHE_PANEL_REGS_SVH
// Clock rate and base tick; the eight times after the tick are in milliseconds of the tick.
`define CLK_KHZ     32'h0000_2710
`define TICK_US     32'h0000_03E8
`define US_PER_MS   32'h0000_03E8
`define DEB_MS      8'h14
`define LONG_MS     16'h03E8
`define OVL_MS      16'h07D0
`define PRESET_MS   16'h07D0
`define REDIT_MS    16'h0BB8
`define SAFETY_MS   16'h03E8
`define RAMP_MS     16'h0064
`define MT_UNIT_MS  16'h0064
// Key positions inside the packed key vector.
`define K_MODE      3'h4
`define K_START     3'h3
`define K_STOP      3'h2
`define K_FAST      3'h1
`define K_MARK      3'h0
// Parameter slots, also the nonvolatile word addresses.
`define P_MAIN      3'h0
`define P_LAND      3'h1
`define P_WIDTH     3'h2
`define P_PITCH     3'h3
`define P_MTIME     3'h4
`define P_LAST      3'h4
// Main parameter bits and displayed speeds.
`define MAIN_SPEED_BIT 0
`define MAIN_HOLD_BIT  1
`define MAIN_MAX    16'h0003
`define SPEED33     16'h0021
`define SPEED45     16'h002D
// Limits and reset defaults (micrometres; mark time in 100 ms units).
`define LAND_MIN    16'h0004
`define LAND_MAX    16'h0078
`define LAND_DEF    16'h0028
`define WIDTH_MIN   16'h0032
`define WIDTH_MAX   16'h0078
`define WIDTH_DEF   16'h0050
`define PITCH_MIN   16'h0190
`define PITCH_MAX   16'h044C
`define PITCH_NOM   16'h0320
`define MT_MIN      16'h0003
`define MT_MAX      16'h000F
`define MT_NOM      16'h000A
// Carriage drive rates.
`define JOG_START   8'h01
`define JOG_MAX     8'hFF
`define FIXED_RATE  8'h40
`endif

// ==== lathe_panel_pkg.sv ====
`default_nettype none
package lathe_panel_pkg;
  typedef struct packed {
    logic mode;
    logic start;
    logic stop;
    logic fast;
    logic mark;
  } key_t;
  typedef enum logic [1:0] {line_monitor = 2'h0, feedback_monitor = 2'h1, pickup_monitor = 2'h2} monitor_t;
  typedef enum logic [3:0] {disp_anim = 4'h1, disp_preset = 4'h2, disp_meter = 4'h4, disp_param = 4'h8} disp_mode_t;
  typedef struct packed {
    disp_mode_t  mode;
    logic [2:0]  sel;
    logic [15:0] value;
  } disp_t;
  typedef enum logic [7:0] {st_load = 8'h01, st_preset = 8'h02, st_stop = 8'h04, st_edit = 8'h08,
                            st_save = 8'h10, st_arm = 8'h20, st_rec = 8'h40, st_redit = 8'h80} state_t;
  typedef enum logic [8:0] {fd_idle = 9'h001, fd_jog = 9'h002, fd_skip = 9'h004, fd_safety = 9'h008,
                            fd_leadin = 9'h010, fd_cut = 9'h020, fd_mark = 9'h040, fd_leadout = 9'h080,
                            fd_lock = 9'h100} feed_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } nvm_req_t;
  typedef struct packed {
    logic [15:0] main;
    logic [15:0] land;
    logic [15:0] width;
    logic [15:0] pitch;
    logic [15:0] mtime;
  } param_set_t;
endpackage
`default_nettype wire

// ==== lathe_panel_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lathe_panel_regs.svh"
module lathe_panel_controller
  import lathe_panel_pkg::*;
#(
  parameter int unsigned TICK_CYC = `CLK_KHZ * `TICK_US / `US_PER_MS
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire key_t        keys,        // High while a key is held.
  input  wire logic        overload,
  input  wire logic        platter_rev, // One pulse per platter revolution.
  input  wire logic        feed_step,   // One pulse per micrometre of travel.
  input  wire logic        area_end,
  input  wire logic        nvm_ack,
  input  wire logic [15:0] nvm_rdata,
  output var  nvm_req_t    nvm,
  output var  disp_t       display,
  output var  key_t        lights,
  output var  monitor_t    monitor,
  output var  logic        amp_mute,
  output var  feed_t       feed_cmd,
  output var  logic [7:0]  motor_rate,
  output var  param_set_t  params
);

  logic [15:0] tick_cnt_r;
  logic        tick;
  logic [4:0]  key_raw;
  logic [4:0]  stable_r;
  logic [4:0]  prev_r;
  logic [4:0]  long_r;
  logic [4:0]  long_prev_r;
  logic [4:0]  press;
  logic [4:0]  rel;
  logic [4:0]  short_rel;
  logic [4:0]  long_ev;
  logic [7:0]  deb_cnt_r [0:4];
  logic [15:0] hold_r [0:4];
  logic [15:0] param_r [0:4];
  state_t      state_r;
  feed_t       feed_r;
  feed_t       feed_nxt;
  logic [2:0]  idx_r;
  logic [2:0]  sel_r;
  logic [15:0] tmr_r;
  logic [15:0] feed_tmr_r;
  logic [15:0] step_cnt_r;
  logic [15:0] ovl_cnt_r;
  logic [15:0] mark_ms;
  logic [7:0]  jog_rate_r;
  logic        rev_seen_r;
  logic        edit_on;
  logic        rec_on;
  logic        rec_go;
  logic        rec_done;
  logic        stop_rec;

  function automatic logic [15:0] lim_lo(input logic [2:0] idx);
    case (idx)
      `P_LAND:  lim_lo = `LAND_MIN;
      `P_WIDTH: lim_lo = `WIDTH_MIN;
      `P_PITCH: lim_lo = `PITCH_MIN;
      `P_MTIME: lim_lo = `MT_MIN;
      default:  lim_lo = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] lim_hi(input logic [2:0] idx);
    case (idx)
      `P_LAND:  lim_hi = `LAND_MAX;
      `P_WIDTH: lim_hi = `WIDTH_MAX;
      `P_PITCH: lim_hi = `PITCH_MAX;
      `P_MTIME: lim_hi = `MT_MAX;
      default:  lim_hi = `MAIN_MAX;
    endcase
  endfunction

  // Bit 16 is the borrow of a decrement below zero, so it clamps low.
  function automatic logic [15:0] clamp(input logic [2:0] idx, input logic [16:0] v);
    if (v[16] || (v[15:0] < lim_lo(idx)))
      clamp = lim_lo(idx);
    else if (v[15:0] > lim_hi(idx))
      clamp = lim_hi(idx);
    else
      clamp = v[15:0];
  endfunction

  // Millisecond tick; every timer in the block counts these pulses.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tick_cnt_r <= 16'h0000;
    else if (tick)
      tick_cnt_r <= 16'h0000;
    else
      tick_cnt_r <= tick_cnt_r + 16'h0001;
  end
  assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

  // debounce and classification.
  // A key changes state only after it has read steady for the debounce time.
  assign key_raw = keys;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stable_r    <= 5'h00;
      prev_r      <= 5'h00;
      long_r      <= 5'h00;
      long_prev_r <= 5'h00;
      for (int i = 0; i < 5; i++)
      begin
        deb_cnt_r[i] <= 8'h00;
        hold_r[i]    <= 16'h0000;
      end
    end
    else
    begin
      prev_r      <= stable_r;
      long_prev_r <= long_r;
      for (int i = 0; i < 5; i++)
      begin
        if (key_raw[i] == stable_r[i])
          deb_cnt_r[i] <= 8'h00;
        else if (tick && (deb_cnt_r[i] == `DEB_MS - 8'h01))
        begin
          stable_r[i]  <= key_raw[i];
          deb_cnt_r[i] <= 8'h00;
        end
        else if (tick)
          deb_cnt_r[i] <= deb_cnt_r[i] + 8'h01;
        if (!stable_r[i])
        begin
          hold_r[i] <= 16'h0000;
          long_r[i] <= 1'b0;
        end
        else if (tick && !long_r[i])
        begin
          hold_r[i] <= hold_r[i] + 16'h0001;
          if (hold_r[i] == `LONG_MS - 16'h0001)
            long_r[i] <= 1'b1;
        end
      end
    end
  end

  // A release counts as short only when the hold never reached one second.
  assign press     = stable_r & ~prev_r;
  assign rel       = ~stable_r & prev_r;
  assign short_rel = rel & ~long_r;
  assign long_ev   = long_r & ~long_prev_r;

  assign edit_on  = (state_r == st_edit) || (state_r == st_redit);
  assign rec_on   = (state_r == st_rec) || (state_r == st_redit);
  assign rec_go   = (state_r == st_arm) && rel[`K_START];
  assign stop_rec = rec_on && press[`K_STOP];
  assign rec_done = (feed_r == fd_lock) && platter_rev && rev_seen_r;
  assign mark_ms  = 16'(param_r[`P_MTIME] * `MT_UNIT_MS);

  // Panel state sequencing; start is not decoded in the recording states.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= st_load;
      idx_r   <= 3'h0;
      sel_r   <= 3'h0;
      tmr_r   <= 16'h0000;
    end
    else
    begin
      case (state_r)
        st_load:
        begin
          if (tick)
            tmr_r <= tmr_r + 16'h0001;
          if (nvm_ack && (idx_r == `P_LAST))
          begin
            idx_r   <= 3'h0;
            tmr_r   <= 16'h0000;
            state_r <= st_preset;
          end
          else if (nvm_ack)
            idx_r <= idx_r + 3'h1;
        end
        st_preset:
        begin
          if (tick)
            tmr_r <= tmr_r + 16'h0001;
          if (tick && (tmr_r == `PRESET_MS - 16'h0001))
            state_r <= st_stop;
        end
        st_stop:
        begin
          if ((feed_r == fd_idle) && long_ev[`K_MODE])
          begin
            sel_r   <= `P_MAIN;
            state_r <= st_edit;
          end
          else if ((feed_r == fd_idle) && press[`K_START])
            state_r <= st_arm;
        end
        st_edit:
        begin
          if (short_rel[`K_MODE])
            sel_r <= (sel_r == `P_LAST) ? `P_MAIN : sel_r + 3'h1;
          if (press[`K_START])
          begin
            idx_r   <= 3'h0;
            state_r <= st_save;
          end
          else if (press[`K_STOP])
            state_r <= st_stop;
        end
        st_save:
        begin
          if (nvm_ack && (idx_r == `P_LAST))
          begin
            idx_r   <= 3'h0;
            state_r <= st_stop;
          end
          else if (nvm_ack)
            idx_r <= idx_r + 3'h1;
        end
        st_arm:
        begin
          if (rec_go)
            state_r <= st_rec;
          else if (press[`K_STOP])
            state_r <= st_stop;
        end
        st_rec:
        begin
          if (rec_done)
            state_r <= st_stop;
          else if (long_ev[`K_MODE])
          begin
            sel_r   <= `P_LAND;
            tmr_r   <= 16'h0000;
            state_r <= st_redit;
          end
        end
        st_redit:
        begin
          if (rec_done)
            state_r <= st_stop;
          else if ((press | short_rel) != 5'h00)
            tmr_r <= 16'h0000;
          else if (tick && (tmr_r == `REDIT_MS - 16'h0001))
            state_r <= st_rec;
          else if (tick)
            tmr_r <= tmr_r + 16'h0001;
          if (short_rel[`K_MODE])
            sel_r <= (sel_r == `P_LAND) ? `P_MTIME : `P_LAND;
        end
        default: state_r <= st_load;
      endcase
    end
  end

  // Working parameters; loaded words are clamped so a blank memory stays legal.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      param_r[`P_MAIN]  <= 16'h0000;
      param_r[`P_LAND]  <= `LAND_DEF;
      param_r[`P_WIDTH] <= `WIDTH_DEF;
      param_r[`P_PITCH] <= `PITCH_NOM;
      param_r[`P_MTIME] <= `MT_NOM;
    end
    else if ((state_r == st_load) && nvm_ack)
      param_r[idx_r] <= clamp(idx_r, {1'b0, nvm_rdata});
    else if (edit_on && press[`K_MARK])
      param_r[sel_r] <= clamp(sel_r, {1'b0, param_r[sel_r]} + 17'h0_0001);
    else if (edit_on && press[`K_FAST])
      param_r[sel_r] <= clamp(sel_r, {1'b0, param_r[sel_r]} - 17'h0_0001);
  end
  assign params = {param_r[`P_MAIN], param_r[`P_LAND], param_r[`P_WIDTH], param_r[`P_PITCH], param_r[`P_MTIME]};

  // Memory requests hold until acknowledged, one word per acknowledge.
  assign nvm = '{req:   (state_r == st_load) || (state_r == st_save),
                 we:    (state_r == st_save),
                 addr:  idx_r,
                 wdata: param_r[idx_r]};

  // Carriage sequence; fast and mark drive the feed only outside editing.
  always_comb
  begin
    feed_nxt = feed_r;
    case (feed_r)
      fd_idle:
        if (rec_go)
          feed_nxt = fd_safety;
        else if ((state_r == st_stop) && press[`K_FAST])
          feed_nxt = fd_jog;
        else if ((state_r == st_stop) && press[`K_MARK])
          feed_nxt = fd_skip;
      fd_jog:
        if (!stable_r[`K_FAST])
          feed_nxt = fd_idle;
      fd_skip:
        if (step_cnt_r >= param_r[`P_PITCH])
          feed_nxt = fd_idle;
      fd_safety:
        if (stop_rec)
          feed_nxt = fd_lock;
        else if (feed_tmr_r >= `SAFETY_MS)
          feed_nxt = fd_leadin;
      fd_leadin:
        if (stop_rec)
          feed_nxt = fd_lock;
        else if (platter_rev && rev_seen_r)
          feed_nxt = fd_cut;
      fd_cut:
        if (stop_rec)
          feed_nxt = fd_lock;
        else if ((state_r == st_rec) && press[`K_FAST])
          feed_nxt = fd_leadout;
        else if ((state_r == st_rec) && press[`K_MARK])
          feed_nxt = fd_mark;
      fd_mark:
        if (stop_rec)
          feed_nxt = fd_lock;
        else if (feed_tmr_r >= mark_ms)
          feed_nxt = fd_cut;
      fd_leadout:
        if (stop_rec || area_end)
          feed_nxt = fd_lock;
        else if ((state_r == st_rec) && press[`K_MARK])
          feed_nxt = fd_cut;
      fd_lock:
        if (rec_done)
          feed_nxt = fd_idle;
      default: feed_nxt = fd_idle;
    endcase
  end

  // Timers restart on every feed change; the revolution flag skips a partial turn.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      feed_r     <= fd_idle;
      feed_tmr_r <= 16'h0000;
      step_cnt_r <= 16'h0000;
      rev_seen_r <= 1'b0;
      jog_rate_r <= `JOG_START;
    end
    else
    begin
      feed_r <= feed_nxt;
      if (feed_nxt != feed_r)
      begin
        feed_tmr_r <= 16'h0000;
        step_cnt_r <= 16'h0000;
        rev_seen_r <= 1'b0;
        jog_rate_r <= `JOG_START;
      end
      else
      begin
        if (platter_rev)
          rev_seen_r <= 1'b1;
        if (feed_step)
          step_cnt_r <= step_cnt_r + 16'h0001;
        if ((feed_r == fd_jog) && tick && (feed_tmr_r == `RAMP_MS - 16'h0001))
        begin
          feed_tmr_r <= 16'h0000;
          if (jog_rate_r != `JOG_MAX)
            jog_rate_r <= jog_rate_r + 8'h01;
        end
        else if (tick && (feed_tmr_r != 16'hFFFF))
          feed_tmr_r <= feed_tmr_r + 16'h0001;
      end
    end
  end

  // Cutting and lockgroove rates come from the groove logic outside, so zero here.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      feed_cmd   <= fd_idle;
      motor_rate <= 8'h00;
    end
    else
    begin
      feed_cmd <= feed_r;
      case (feed_r)
        fd_jog:                                motor_rate <= jog_rate_r;
        fd_skip, fd_leadin, fd_mark, fd_leadout: motor_rate <= `FIXED_RATE;
        default:                               motor_rate <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      monitor <= line_monitor;
    else if (short_rel[`K_MODE] && ((state_r == st_stop) || (state_r == st_rec)))
    begin
      case (monitor)
        line_monitor:     monitor <= feedback_monitor;
        feedback_monitor: monitor <= pickup_monitor;
        default:          monitor <= line_monitor;
      endcase
    end
  end

  // overload mute
  // Mute releases as soon as the overload clears.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ovl_cnt_r <= 16'h0000;
      amp_mute  <= 1'b0;
    end
    else if (!overload)
    begin
      ovl_cnt_r <= 16'h0000;
      amp_mute  <= 1'b0;
    end
    else if (tick && !amp_mute)
    begin
      ovl_cnt_r <= ovl_cnt_r + 16'h0001;
      if (ovl_cnt_r == `OVL_MS)
        amp_mute <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      display <= '{mode: disp_anim, sel: 3'h0, value: 16'h0000};
    else
    begin
      case (state_r)
        st_load:   display <= '{mode: disp_anim, sel: 3'h0, value: {13'h0000, tmr_r[9:7]}};
        st_preset: display <= '{mode: disp_preset, sel: `P_MAIN,
                                value: param_r[`P_MAIN][`MAIN_SPEED_BIT] ? `SPEED45 : `SPEED33};
        st_edit, st_redit, st_save:
                   display <= '{mode: disp_param, sel: sel_r, value: param_r[sel_r]};
        default:   display <= '{mode: disp_meter, sel: 3'h0, value: 16'h0000};
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      lights <= 5'h00;
    else
    begin
      lights.mode  <= edit_on || (state_r == st_save);
      lights.start <= (state_r == st_arm) || rec_on;
      lights.stop  <= (state_r == st_stop);
      lights.fast  <= (feed_r == fd_jog) || (feed_r == fd_leadout);
      lights.mark  <= (feed_r == fd_safety) || (feed_r == fd_leadin) || (feed_r == fd_mark) || (feed_r == fd_skip);
    end
  end

endmodule
`default_nettype wire

// ==== lathe_panel_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lathe_panel_regs.svh"
module lathe_panel_checker
  import lathe_panel_pkg::*;
#(
  parameter int unsigned TICK_CYC = 10
)(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       overload,
  input wire logic       nvm_ack,
  input wire nvm_req_t   nvm,
  input wire disp_t      display,
  input wire logic       amp_mute,
  input wire param_set_t params
);
  logic [31:0] ovl_cnt_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Overload hold time in clocks, so that a short burst never counts toward muting.
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ovl_cnt_r <= '0;
    else if (!overload)
      ovl_cnt_r <= '0;
    else
      ovl_cnt_r <= ovl_cnt_r + 32'h0000_0001;
  // The power-up load ends on the acknowledge of the last word, then the preset shows.
  sequence word_taken;
    nvm.req && nvm_ack;
  endsequence
  sequence last_load_word;
    word_taken ##0 (nvm.addr == 3'h4 && !nvm.we);
  endsequence
  sequence preset_shown;
    !nvm.req ##1 (display.mode == disp_preset && display.value inside {`SPEED33, `SPEED45});
  endsequence
  a_load_then_preset: assert property (last_load_word |=> preset_shown)
    else $error("load end not followed by preset");
  a_nvm_req_holds: assert property (nvm.req && !nvm_ack |=> nvm.req && $stable(nvm))
    else $error("memory request moved before acknowledge");
  a_mute_needs_hold: assert property (overload && amp_mute |-> ovl_cnt_r >= 1999 * TICK_CYC)
    else $error("mute came too early");
  a_mute_in_time: assert property (ovl_cnt_r == 2003 * TICK_CYC |-> amp_mute)
    else $error("mute came too late");
  a_mute_clears: assert property (!overload |=> !amp_mute)
    else $error("mute stayed without overload");
  a_land_limits: assert property (params.land inside {[`LAND_MIN:`LAND_MAX]})
    else $error("land out of range");
  a_width_limits: assert property (params.width inside {[`WIDTH_MIN:`WIDTH_MAX]})
    else $error("width out of range");
  a_pitch_limits: assert property (params.pitch inside {[`PITCH_MIN:`PITCH_MAX]})
    else $error("pitch out of range");
  a_mtime_limits: assert property (params.mtime inside {[`MT_MIN:`MT_MAX]})
    else $error("mark time out of range");
endmodule
bind lathe_panel_controller lathe_panel_checker #(.TICK_CYC(TICK_CYC)) i_lathe_panel_checker (
  .ref_clk, .rst, .overload, .nvm_ack, .nvm, .display, .amp_mute, .params
);
`default_nettype wire

// ==== lathe_panel_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module lathe_panel_partner
  import lathe_panel_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire nvm_req_t    nvm,
  input  wire feed_t       feed_cmd,
  output var  logic        nvm_ack,
  output var  logic [15:0] nvm_rdata,
  output var  logic        platter_rev,
  output var  logic        feed_step
);
  logic [15:0] mem [5];
  logic [2:0]  wait_r;
  logic [10:0] turn_r;
  // Stored words; land and width sit outside their limits so the load must clamp them.
  initial
    mem = '{16'h0001, 16'h00C8, 16'h000A, 16'h0384, 16'h0005};
  // Odd words answer slowly and even words promptly; a write lands with its acknowledge.
  always @(posedge ref_clk or posedge rst)
    if (rst || nvm_ack || !nvm.req)
    begin
      wait_r  <= 3'h0;
      nvm_ack <= 1'b0;
    end
    else if (wait_r == (nvm.addr[0] ? 3'h5 : 3'h1))
    begin
      nvm_ack <= 1'b1;
      if (nvm.we)
        mem[nvm.addr] <= nvm.wdata;
    end
    else
      wait_r <= wait_r + 3'h1;
  // Off the acknowledge the data lines carry the inverse, never a stale word.
  assign nvm_rdata = nvm_ack ? mem[nvm.addr] : ~mem[nvm.addr];
  // One platter turn every 2000 clocks; the carriage steps every fourth clock while driven.
  always @(posedge ref_clk or posedge rst)
    if (rst)
      turn_r <= 11'h000;
    else
      turn_r <= (turn_r == 11'h7CF) ? 11'h000 : turn_r + 11'h001;
  assign platter_rev = (turn_r == 11'h000);
  assign feed_step   = (turn_r[1:0] == 2'h0) && (feed_cmd != fd_idle);
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lathe_panel_regs.svh"
module testbench
  import lathe_panel_pkg::*;
;
  typedef struct {
    string       what;
    logic [15:0] v;
  } note_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  key_t        keys = '0;
  logic        overload = 1'b0;
  logic        area_end = 1'b0;
  logic        nvm_ack;
  logic        platter_rev;
  logic        feed_step;
  logic        amp_mute;
  logic [15:0] nvm_rdata;
  logic [7:0]  motor_rate;
  nvm_req_t    nvm;
  disp_t       display;
  key_t        lights;
  monitor_t    monitor;
  feed_t       feed_cmd;
  param_set_t  params;
  note_t       notes [$];
  int          failures = 0;
  int          n_compared = 0;
  int          n;
  // A short tick keeps the one and two second figures within a short run.
  lathe_panel_controller #(.TICK_CYC(10)) i_lathe_panel_controller (
    .ref_clk, .rst, .keys, .overload, .platter_rev, .feed_step, .area_end, .nvm_ack, .nvm_rdata,
    .nvm, .display, .lights, .monitor, .amp_mute, .feed_cmd, .motor_rate, .params
  );
  lathe_panel_partner i_lathe_panel_partner (
    .ref_clk, .rst, .nvm, .feed_cmd, .nvm_ack, .nvm_rdata, .platter_rev, .feed_step
  );
  // Clock of 10 MHz.
  always #50 ref_clk = ~ref_clk;
  function automatic logic [15:0] seen(input string what);
    case (what)
      "monitor": return 16'(monitor);
      "mode": return 16'(display.mode);
      "sel": return 16'(display.sel);
      "land": return params.land;
      "width": return params.width;
      "mtime": return params.mtime;
      "mute": return 16'(amp_mute);
      "feed": return 16'(feed_cmd);
      "value": return display.value;
      "rate": return 16'(motor_rate);
      "start_lamp": return 16'(lights.start);
      "saved": return i_lathe_panel_partner.mem[1];
      default: return 16'(lights.mark);
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic note(input string what, input logic [15:0] v);
    notes.push_back('{what, v});
  endtask
  // Inputs move 5 ns after a rising edge, so no race with the design's sampling.
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #5;
  endtask
  // Holds outlast the debounce by a random margin; only the 10400-clock hold reaches a long press.
  task automatic key(input int b, input logic down, input int hold);
    keys[b] = down;
    cyc(hold + int'($urandom % 64));
  endtask
  task automatic press(input int b);
    key(b, 1'b1, 300);
    key(b, 1'b0, 300);
  endtask
  // Notes are judged at the falling edge, when the registered outputs have settled.
  always @(negedge ref_clk)
    while (notes.size() > 0)
    begin
      check(notes[0].what, seen(notes[0].what), notes[0].v);
      void'(notes.pop_front());
    end
  initial
  begin
    void'($urandom(50));
    cyc(3);
    rst = 1'b0;
    cyc(1);
    note("mode", disp_anim);
    cyc(100);
    note("mode", disp_preset);
    note("land", `LAND_MAX);
    note("width", `WIDTH_MIN);
    note("value", `SPEED45);
    overload = 1'b1;
    cyc(19800);
    note("mute", 16'h0000);
    cyc(400);
    note("mute", 16'h0001);
    note("mode", disp_meter);
    overload = 1'b0;
    cyc(3);
    note("mute", 16'h0000);
    for (int i = 1; i <= 3; i++)
    begin
      press(`K_MODE);
      note("monitor", 16'(i % 3));
    end
    key(`K_MODE, 1'b1, 10400);
    note("mode", disp_param);
    key(`K_MODE, 1'b0, 300);
    note("sel", 16'h0000);
    press(`K_MODE);
    note("sel", 16'h0001);
    press(`K_MARK);
    note("land", `LAND_MAX);
    n = 1 + $urandom % 3;
    repeat (n) press(`K_FAST);
    note("land", `LAND_MAX - 16'(n));
    repeat (3) press(`K_MODE);
    note("sel", 16'h0004);
    repeat (3) press(`K_FAST);
    note("mtime", `MT_MIN);
    press(`K_MODE);
    note("sel", 16'h0000);
    press(`K_START);
    note("mode", disp_meter);
    note("saved", `LAND_MAX - 16'(n));
    key(`K_START, 1'b1, 300);
    note("start_lamp", 16'h0001);
    note("feed", fd_idle);
    key(`K_START, 1'b0, 300);
    note("feed", fd_safety);
    note("mark_lamp", 16'h0001);
    cyc(14400);
    note("feed", fd_cut);
    note("mark_lamp", 16'h0000);
    press(`K_MODE);
    note("monitor", feedback_monitor);
    press(`K_START);
    note("feed", fd_cut);
    press(`K_MARK);
    note("feed", fd_mark);
    cyc(3000);
    note("feed", fd_cut);
    press(`K_FAST);
    note("feed", fd_leadout);
    press(`K_MARK);
    note("feed", fd_cut);
    press(`K_FAST);
    area_end = 1'b1;
    cyc(2);
    note("feed", fd_lock);
    area_end = 1'b0;
    cyc(4400);
    note("feed", fd_idle);
    // A second take is stopped while still in its safety groove.
    key(`K_START, 1'b1, 300);
    key(`K_START, 1'b0, 300);
    press(`K_STOP);
    note("feed", fd_lock);
    note("start_lamp", 16'h0001);
    cyc(4400);
    note("feed", fd_idle);
    note("start_lamp", 16'h0000);
    // Two ramp steps of the jog fall inside this hold, none a third.
    key(`K_FAST, 1'b1, 2500);
    note("feed", fd_jog);
    note("rate", 16'(`JOG_START) + 16'h0002);
    key(`K_FAST, 1'b0, 300);
    note("feed", fd_idle);
    note("rate", 16'h0000);
    press(`K_MARK);
    note("feed", fd_skip);
    note("rate", 16'(`FIXED_RATE));
    cyc(3600);
    note("feed", fd_idle);
    cyc(2);
    summarize();
  end
  // A hang is cut short well beyond the expected length of the run.
  initial
  begin
    cyc(95000);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
